// *** urx_receiver.v ***
// urx_receiver.v: asynchronous serial receiver with two-entry buffer and status
// assumes: one clock, baud sample tick from outside, line input already synchronous
//
// How it works
// - receive-complete flag is one exactly while the buffer holds an unread character
// - clearing receiver enable empties the buffer at once
// - interrupt request = flag and irq enable and global enable
// - error flags stored per entry; data read advances read position
// - status writes do not change the error flags
// - error flags never raise an interrupt
// - frame error shows voted first stop bit of oldest entry
// - only the first stop bit is checked, stop count ignored
// - overrun when buffer full, frame waiting, and new start seen
// - overrun flag clear when frame moves into the buffer normally
// - parity error reads zero for characters received while checking disabled
// - parity checked only while parity enable set; odd select picks type
// - parity computed over data, compared, stored with character
// - parity error valid for oldest entry until data read
// - disable abandons reception and frees the pin
// - sixteen samples per bit normally, eight in double speed
// - start bit voted on samples 8,9,10 or 4,5,6 after first low
// - noisy start rejected; valid start aligns bit timing every frame
// - each bit decided by majority of three centre samples
// - frame error set when voted first stop bit is low
`timescale 1ns/1ps
`include "urx_map.vh"

module urx_receiver #(
  parameter DATA_W = 8
) (
  // clock, reset, enable
  input wire I_SYS_CLK,
  input wire I_RST,
  input wire I_CLK_EN,
  // sample tick, serial line and global interrupt enable
  input wire I_SAMPLE_TICK,
  input wire I_RXD,
  input wire I_GLOBAL_IRQ_EN,
  // avalon-mm slave
  input wire [3:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  output reg [31:0] O_AVS_READDATA,
  output reg O_AVS_WAITREQUEST,
  // outputs
  output reg O_RX_IRQ,
  output reg O_RXD_OVERRIDE
);

  // ==========================================
  // states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_START = 3'b010;
  localparam [2:0] ST_BITS = 3'b100;

  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  function [7:0] mask_data;
    input [7:0] d;
    input [1:0] csz;
    begin
      mask_data = d & (8'hff >> (2'h3 - csz));
    end
  endfunction

  // ==========================================
  // registers
  reg [7:0] ctrl_reg;
  reg [7:0] fmt_reg;
  reg [2:0] state_reg;
  reg [4:0] smp_reg;
  reg [3:0] bit_reg;
  reg [2:0] vote_reg;
  reg [7:0] shift_reg;
  reg par_reg;
  reg prev_rxd_reg;
  reg wait_reg;
  reg [7:0] wait_data_reg;
  reg wait_fe_reg;
  reg wait_pe_reg;
  reg ovr_pend_reg;
  reg [7:0] buf_data_reg [0:1];
  reg [2:0] buf_err_reg [0:1];
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  reg ack_reg;

  wire rxen = ctrl_reg[`URX_CT_RXEN];
  wire dbl = fmt_reg[`URX_FM_U2X];
  wire [4:0] ovs = dbl ? `URX_OVS_DBL : `URX_OVS_NORM;
  wire [4:0] vfirst = dbl ? `URX_VOTE_DBL : `URX_VOTE_NORM;
  wire [1:0] csz = fmt_reg[`URX_FM_CSZ_HI:`URX_FM_CSZ_LO];
  wire pen = fmt_reg[`URX_FM_PEN];
  wire [3:0] nbits = `URX_DATA_MIN + {2'h0, csz} + {3'h0, pen};
  wire [1:0] word = I_AVS_ADDRESS[3:2];
  wire bus_req = (I_AVS_READ | I_AVS_WRITE) & ~ack_reg;
  // access completes at the edge where waitrequest is seen low
  wire bus_ack = (I_AVS_READ | I_AVS_WRITE) & ~O_AVS_WAITREQUEST;
  wire data_rd = bus_ack & I_AVS_READ & (word == `URX_IDX_DATA) & I_CLK_EN;
  wire tick = I_CLK_EN & I_SAMPLE_TICK & rxen;
  wire [2:0] vote_now = {vote_reg[1:0], I_RXD};
  wire vote_last = (smp_reg == vfirst + 5'h2);
  wire bit_val = maj3(vote_now);
  wire rxc = (count_reg != 2'h0);
  wire [2:0] head_err = buf_err_reg[rd_ptr_reg];
  wire wr_ctrl = bus_ack & I_AVS_WRITE & (word == `URX_IDX_CTRL) & I_CLK_EN;
  wire rxen_next = wr_ctrl ? I_AVS_WRITEDATA[`URX_CT_RXEN] : rxen;

  // ==========================================
  // receive engine
  always @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
      smp_reg <= 5'h00;
      bit_reg <= 4'h0;
      vote_reg <= 3'h0;
      shift_reg <= 8'h00;
      par_reg <= 1'b0;
      prev_rxd_reg <= 1'b1;
      wait_reg <= 1'b0;
      wait_data_reg <= 8'h00;
      wait_fe_reg <= 1'b0;
      wait_pe_reg <= 1'b0;
      ovr_pend_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      buf_data_reg[0] <= 8'h00;
      buf_data_reg[1] <= 8'h00;
      buf_err_reg[0] <= 3'h0;
      buf_err_reg[1] <= 3'h0;
    end else if (I_CLK_EN) begin
      if (!rxen_next) begin
        // abandon reception and flush
        state_reg <= ST_IDLE;
        count_reg <= 2'h0;
        rd_ptr_reg <= 1'b0;
        wait_reg <= 1'b0;
        ovr_pend_reg <= 1'b0;
        prev_rxd_reg <= 1'b1;
      end else begin
        // move waiting frame into buffer when room
        if (wait_reg && (count_reg != 2'h2 || data_rd)) begin
          buf_data_reg[rd_ptr_reg ^ count_reg[0]] <= wait_data_reg;
          buf_err_reg[rd_ptr_reg ^ count_reg[0]] <=
            {wait_fe_reg, ovr_pend_reg, wait_pe_reg};
          ovr_pend_reg <= 1'b0;
          wait_reg <= 1'b0;
          count_reg <= data_rd ? count_reg : count_reg + 2'h1;
        end else if (data_rd && rxc) begin
          count_reg <= count_reg - 2'h1;
        end
        if (data_rd && rxc) begin
          rd_ptr_reg <= ~rd_ptr_reg;
        end
        if (tick) begin
          prev_rxd_reg <= I_RXD;
          vote_reg <= vote_now;
          case (state_reg)
            ST_IDLE: begin
              if (prev_rxd_reg && !I_RXD) begin
                state_reg <= ST_START;
                smp_reg <= 5'h01;
                if (wait_reg && count_reg == 2'h2 && !data_rd) begin
                  ovr_pend_reg <= 1'b1;
                  wait_reg <= 1'b0;
                end
              end
            end
            ST_START: begin
              smp_reg <= smp_reg + 5'h01;
              if (vote_last) begin
                if (bit_val) begin
                  state_reg <= ST_IDLE;
                end else begin
                  state_reg <= ST_BITS;
                  smp_reg <= vfirst + 5'h3 - ovs;
                  bit_reg <= 4'h0;
                  par_reg <= 1'b0;
                  shift_reg <= 8'h00;
                end
              end
            end
            ST_BITS: begin
              smp_reg <= (smp_reg == ovs) ? 5'h01 : smp_reg + 5'h01;
              if (vote_last) begin
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg < nbits) begin
                  if (bit_reg < nbits - {3'h0, pen}) begin
                    shift_reg[bit_reg[2:0]] <= bit_val;
                  end
                  par_reg <= par_reg ^ bit_val;
                end else begin
                  // first stop bit only; second ignored
                  state_reg <= ST_IDLE;
                  prev_rxd_reg <= 1'b1;
                  wait_reg <= 1'b1;
                  wait_data_reg <= mask_data(shift_reg, csz);
                  wait_fe_reg <= ~bit_val;
                  // even: total ones even; odd: total ones odd
                  wait_pe_reg <= pen & (par_reg ^ fmt_reg[`URX_FM_PODD]);
                end
              end
            end
            default: state_reg <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // ==========================================
  // avalon slave, one wait cycle per access
  always @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg <= `URX_CT_RESET;
      fmt_reg <= `URX_FM_RESET;
      ack_reg <= 1'b0;
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h00000000;
      O_RX_IRQ <= 1'b0;
      O_RXD_OVERRIDE <= 1'b0;
    end else if (I_CLK_EN) begin
      ack_reg <= bus_req;
      O_AVS_WAITREQUEST <= ~bus_req;
      O_RX_IRQ <= rxc & ctrl_reg[`URX_CT_RXCIE] & I_GLOBAL_IRQ_EN;
      O_RXD_OVERRIDE <= rxen_next;
      if (wr_ctrl) begin
        ctrl_reg <= I_AVS_WRITEDATA[7:0];
      end
      if (bus_ack && I_AVS_WRITE && word == `URX_IDX_FMT) begin
        fmt_reg <= I_AVS_WRITEDATA[7:0];
      end
      // status writes ignored: flags are read-only
      if (bus_req && I_AVS_READ) begin
        case (word)
          `URX_IDX_DATA: O_AVS_READDATA <= {24'h0, rxc ? buf_data_reg[rd_ptr_reg] : 8'h00};
          `URX_IDX_STAT: O_AVS_READDATA <= {24'h0, rxc, 2'h0,
            rxc & head_err[2], rxc & head_err[1], rxc & head_err[0], 2'h0};
          `URX_IDX_CTRL: O_AVS_READDATA <= {24'h0, ctrl_reg};
          `URX_IDX_FMT: O_AVS_READDATA <= {24'h0, fmt_reg};
          default: O_AVS_READDATA <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // urx_receiver

// *** urx_map.vh ***
// urx_map.vh: register offsets, field positions and reset values of the receiver
// assumes: included by urx_receiver.v only
`ifndef URX_MAP_VH
`define URX_MAP_VH
// ==========================================
// register word offsets (byte address = 4 * index)
`define URX_IDX_DATA 2'h0
`define URX_IDX_STAT 2'h1
`define URX_IDX_CTRL 2'h2
`define URX_IDX_FMT 2'h3
// ==========================================
// status fields
`define URX_ST_PE 2
`define URX_ST_DOR 3
`define URX_ST_FE 4
`define URX_ST_RXC 7
// ==========================================
// control fields
`define URX_CT_RXEN 4
`define URX_CT_RXCIE 7
`define URX_CT_RESET 8'h00
// ==========================================
// format fields
`define URX_FM_U2X 0
`define URX_FM_SBS 3
`define URX_FM_PODD 4
`define URX_FM_PEN 5
`define URX_FM_CSZ_LO 1
`define URX_FM_CSZ_HI 2
`define URX_FM_RESET 8'h06
// ==========================================
// sampling figures
`define URX_OVS_NORM 5'h10
`define URX_OVS_DBL 5'h08
`define URX_VOTE_NORM 5'h08
`define URX_VOTE_DBL 5'h04
`define URX_DATA_MIN 4'h5
`endif

// *** urx_chk_sva.sv ***
// urx_chk_sva.sv: port-level assertions for the receiver
// assumes: bound onto urx_receiver, one clock
`timescale 1ns/1ps
module urx_chk (
  input wire I_SYS_CLK,
  input wire I_RST,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [3:0] I_AVS_ADDRESS,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire I_GLOBAL_IRQ_EN,
  input wire [31:0] O_AVS_READDATA,
  input wire O_AVS_WAITREQUEST,
  input wire O_RX_IRQ,
  input wire O_RXD_OVERRIDE
);
  // ========
  // helper state
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  wire req = I_AVS_READ | I_AVS_WRITE;
  wire ack = req & !O_AVS_WAITREQUEST;
  wire wr_ctl = ack & I_AVS_WRITE & (I_AVS_ADDRESS[3:2] == 2'h2);
  wire wr_fmt = ack & I_AVS_WRITE & (I_AVS_ADDRESS[3:2] == 2'h3);
  wire rd_st = ack & I_AVS_READ & (I_AVS_ADDRESS[3:2] == 2'h1);
  reg cie_reg;
  reg pen_reg;
  always @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      cie_reg <= 1'b0;
      pen_reg <= 1'b0;
    end else begin
      if (wr_ctl) cie_reg <= I_AVS_WRITEDATA[7];
      if (wr_fmt) pen_reg <= pen_reg | I_AVS_WRITEDATA[5];
    end
  end
  // ========
  // assertions
  a_ack_bounded: assert property (req && O_AVS_WAITREQUEST |-> ##[1:2] !O_AVS_WAITREQUEST)
    else $error("bus answer late");
  a_ack_pulse: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_rdata_byte: assert property (ack && I_AVS_READ |-> O_AVS_READDATA[31:8] == 24'h0)
    else $error("read upper bits set");
  a_irq_global: assert property (!I_GLOBAL_IRQ_EN |=> !O_RX_IRQ)
    else $error("irq without global enable");
  a_irq_enable: assert property (!cie_reg |=> !O_RX_IRQ)
    else $error("irq without irq enable");
  a_pin_on: assert property (wr_ctl && I_AVS_WRITEDATA[4] |-> ##1 O_RXD_OVERRIDE)
    else $error("pin not taken");
  a_pin_off: assert property (wr_ctl && !I_AVS_WRITEDATA[4] |-> ##1 !O_RXD_OVERRIDE)
    else $error("pin not freed");
  a_flush_irq: assert property (!O_RXD_OVERRIDE && $past(!O_RXD_OVERRIDE) |-> !O_RX_IRQ)
    else $error("irq while disabled");
  a_par_off: assert property (rd_st && !pen_reg |-> !O_AVS_READDATA[2])
    else $error("parity flag with checking off");
  c_read: cover property (rd_st && O_AVS_READDATA[7]);
  c_irq: cover property (O_RX_IRQ);
  c_off: cover property (wr_ctl && !I_AVS_WRITEDATA[4]);
endmodule // urx_chk
bind urx_receiver urx_chk i_chk (.*);

// *** urx_tx_model.sv ***
// urx_tx_model.sv: far-end serial transmitter model
// assumes: tick pulses every other clock, line idles high
`timescale 1ns/1ps
module urx_tx_model (
  input wire clk,
  input wire tick,
  input wire dbl,
  output reg line
);
  initial line = 1'b1;
  task bt(input b);
    integer n;
    begin
      line <= b;
      n = 0;
      while (n < (dbl ? 8 : 16)) begin
        @(posedge clk);
        if (tick) n = n + 1;
      end
    end
  endtask
  task send(input [7:0] d, input pe, input p, input s);
    integer i;
    begin
      bt(1'b0);
      for (i = 0; i < 8; i = i + 1) bt(d[i]);
      if (pe) bt(p);
      bt(s);
      bt(1'b1);
    end
  endtask
  task spike;
    begin
      line <= 1'b0;
      repeat (8) @(posedge clk);
      bt(1'b1);
    end
  endtask
endmodule // urx_tx_model

// *** tb_uart_receiver_status_and_start_detect.sv ***
// tb_uart_receiver_status_and_start_detect.sv: self-checking bench
// assumes: urx_receiver, urx_tx_model and urx_chk compiled first
`timescale 1ns/1ps
module tb_uart_receiver_status_and_start_detect;
  reg clk, rst, tk, gie, rd, wr, dbl;
  reg [3:0] ad;
  reg [31:0] wd, q;
  wire [31:0] rdat;
  wire wq, irq, ovr, rxd;
  integer fails = 0, checks_done = 0, i;
  urx_receiver i_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_CLK_EN(1'b1), .I_SAMPLE_TICK(tk),
    .I_RXD(rxd), .I_GLOBAL_IRQ_EN(gie), .I_AVS_ADDRESS(ad), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wq), .O_RX_IRQ(irq), .O_RXD_OVERRIDE(ovr));
  urx_tx_model i_tx (.clk(clk), .tick(tk), .dbl(dbl), .line(rxd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) tk <= ~tk;
  // ========
  // tasks
  task close_out;
    begin
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("unexpected %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      rd <= !w;
      wr <= w;
      ad <= a;
      wd <= {24'h0, d};
      do @(posedge clk); while (wq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task rs(input [7:0] e);
    begin
      bus(1'b0, 4'h4, 8'h00);
      chk("status", {24'h0, e}, q);
    end
  endtask
  task rdd(input [7:0] e);
    begin
      bus(1'b0, 4'h0, 8'h00);
      chk("data", {24'h0, e}, q);
    end
  endtask
  // ========
  // tests
  initial begin
    rst = 1'b1; tk = 1'b0; gie = 1'b1; rd = 1'b0; wr = 1'b0; dbl = 1'b0; ad = 4'h0; wd = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rs(8'h00);
    bus(1'b1, 4'h8, 8'h90);
    i_tx.send(8'h55, 1'b0, 1'b0, 1'b1);
    chk("pin", 32'h1, {31'h0, ovr});
    rs(8'h80);
    chk("irq", 32'h1, {31'h0, irq});
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    gie <= 1'b1;
    rdd(8'h55);
    rs(8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    i_tx.send(8'ha3, 1'b0, 1'b0, 1'b0);
    i_tx.send(8'h0f, 1'b0, 1'b0, 1'b1);
    rs(8'h90);
    bus(1'b1, 4'h4, 8'h00);
    rs(8'h90);
    rdd(8'ha3);
    rs(8'h80);
    rdd(8'h0f);
    bus(1'b1, 4'hc, 8'h2e);
    i_tx.send(8'h07, 1'b1, 1'b0, 1'b1);
    bus(1'b1, 4'hc, 8'h36);
    i_tx.send(8'h07, 1'b1, 1'b0, 1'b1);
    rs(8'h84);
    rdd(8'h07);
    rs(8'h80);
    rdd(8'h07);
    bus(1'b1, 4'hc, 8'h06);
    for (i = 0; i < 4; i = i + 1) i_tx.send(8'h10 + i[7:0], 1'b0, 1'b0, 1'b1);
    rs(8'h80);
    rdd(8'h10);
    rs(8'h80);
    rdd(8'h11);
    rs(8'h88);
    rdd(8'h13);
    rs(8'h00);
    i_tx.spike;
    rs(8'h00);
    dbl <= 1'b1;
    bus(1'b1, 4'hc, 8'h07);
    i_tx.send(8'h3c, 1'b0, 1'b0, 1'b1);
    rs(8'h80);
    rdd(8'h3c);
    i_tx.send(8'h5a, 1'b0, 1'b0, 1'b1);
    bus(1'b1, 4'h8, 8'h80);
    repeat (2) @(posedge clk);
    chk("pin", 32'h0, {31'h0, ovr});
    rs(8'h00);
    close_out;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails = fails + 1;
    close_out;
  end
endmodule // tb_uart_receiver_status_and_start_detect
